//--- bcsd_core.sv
// Summary of operation
// RULE1: test ANDs a register with itself, sets Z, N and V (V cleared) in one cycle.
// RULE2: pointer jump loads pc from Z in two cycles, flags untouched.
// RULE3: pointer call pushes the return address, loads pc from Z, three cycles, no flags.
// RULE4: compare-skip skips the next instruction when the registers are equal, 1/2/3 cycles.
// RULE5: compare-immediate subtracts a constant without storing, sets Z,N,V,C,H in one cycle.
// RULE6: skip-bit-clear skips the next instruction when the chosen bit is zero.
// RULE7: skip-bit-set skips the next instruction when the chosen bit is one.
// RULE8: branch-flag-set jumps to pc+k+1 when the chosen flag is one, 1 or 2 cycles.
// RULE9: branch-flag-clear jumps to pc+k+1 when the chosen flag is zero, no flag change.
// RULE10: branch-equal jumps only when Z is one, else falls through.
// RULE11: branch-carry-clear jumps only when C is zero, no flag change.
// RULE12: relative jump adds k+1 to pc in two cycles, no flag change.
// RULE13: return pops pc from the stack in four cycles, flags unchanged.
`timescale 1ns/1ns
`default_nettype none
module bcsd_core (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // instruction from fetch
  input wire logic issue_i,
  input wire logic [3:0] op_i,
  input wire logic [7:0] rd_val_i,
  input wire logic [7:0] rr_val_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] sel_i,
  input wire logic [11:0] offset_i,
  input wire logic next_long_i,
  input wire logic [15:0] z_ptr_i,
  // state outputs
  output logic busy_o,
  output logic done_o,
  output logic [15:0] pc_o,
  output logic [7:0] status_flags_o,
  output logic [15:0] sp_o,
  output logic [2:0] cycles_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [11:0] k);
    rel_target = pc + {{4{k[11]}}, k} + bcsd_pkg::STEP_ONE;
  endfunction : rel_target

  function automatic logic [15:0] skip_step(input logic take, input logic long_next);
    if (!take)
      skip_step = bcsd_pkg::STEP_ONE;
    else if (long_next)
      skip_step = bcsd_pkg::STEP_THREE;
    else
      skip_step = bcsd_pkg::STEP_TWO;
  endfunction : skip_step

  function automatic logic [2:0] skip_cycles(input logic take, input logic long_next);
    if (!take)
      skip_cycles = bcsd_pkg::CYC_ONE;
    else if (long_next)
      skip_cycles = bcsd_pkg::CYC_THREE;
    else
      skip_cycles = bcsd_pkg::CYC_TWO;
  endfunction : skip_cycles

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {IDLE, WAIT, PUSH_HI, POP_LO, POP_HI} bcsd_state_type;

  bcsd_state_type state_ff, nxt_state;
  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] pc_pend_ff, nxt_pc_pend;
  logic [7:0] flags_ff, nxt_flags;
  logic [15:0] sp_ff, nxt_sp;
  logic [2:0] wait_ff, nxt_wait;
  logic [2:0] cyc_ff, nxt_cyc;
  logic done_ff, nxt_done;
  logic [7:0] pop_lo_ff, nxt_pop_lo;
  logic [15:0] ret_addr_ff, nxt_ret_addr;

  logic st_wr;
  logic [6:0] st_waddr;
  logic [7:0] st_wdata;
  logic [6:0] st_raddr;
  logic [7:0] st_rdata;

  bcsd_stack u_stack (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(st_wr),
    .wr_addr_i(st_waddr),
    .wr_data_i(st_wdata),
    .rd_addr_i(st_raddr),
    .rd_data_o(st_rdata)
  );

  logic [8:0] diff;
  logic [4:0] hdiff;
  logic [7:0] tst_res;
  logic cond;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_pc_pend = pc_pend_ff;
    nxt_flags = flags_ff;
    nxt_sp = sp_ff;
    nxt_wait = wait_ff;
    nxt_cyc = cyc_ff;
    nxt_done = 1'b0;
    nxt_pop_lo = pop_lo_ff;
    nxt_ret_addr = ret_addr_ff;
    st_wr = 1'b0;
    st_waddr = sp_ff[6:0];
    st_wdata = 8'h00;
    st_raddr = sp_ff[6:0];
    diff = {1'b0, rd_val_i} - {1'b0, imm_i};
    hdiff = {1'b0, rd_val_i[3:0]} - {1'b0, imm_i[3:0]};
    tst_res = rd_val_i & rd_val_i;
    cond = 1'b0;
    case (state_ff)
      IDLE:
      begin
        if (issue_i)
        begin
          nxt_cyc = bcsd_pkg::CYC_ONE;
          nxt_pc = pc_ff + bcsd_pkg::STEP_ONE;
          case (op_i)
            bcsd_pkg::test_zero_minus_op:
            begin
              nxt_flags[bcsd_pkg::FLAG_Z] = (tst_res == 8'h00); // [RULE1]
              nxt_flags[bcsd_pkg::FLAG_N] = tst_res[7]; // [RULE1]
              nxt_flags[bcsd_pkg::FLAG_V] = 1'b0; // [RULE1]
              nxt_flags[bcsd_pkg::FLAG_S] = tst_res[7];
              nxt_done = 1'b1;
            end
            bcsd_pkg::compare_immediate_op:
            begin
              // flags only; the difference is never written back
              nxt_flags[bcsd_pkg::FLAG_Z] = (diff[7:0] == 8'h00); // [RULE5]
              nxt_flags[bcsd_pkg::FLAG_N] = diff[7]; // [RULE5]
              nxt_flags[bcsd_pkg::FLAG_V] = (rd_val_i[7] ^ imm_i[7]) & (rd_val_i[7] ^ diff[7]); // [RULE5]
              nxt_flags[bcsd_pkg::FLAG_C] = diff[8]; // [RULE5]
              nxt_flags[bcsd_pkg::FLAG_H] = hdiff[4]; // [RULE5]
              nxt_flags[bcsd_pkg::FLAG_S] = diff[7] ^
                ((rd_val_i[7] ^ imm_i[7]) & (rd_val_i[7] ^ diff[7]));
              nxt_done = 1'b1;
            end
            bcsd_pkg::pointer_jump_op:
            begin
              nxt_pc_pend = z_ptr_i; // [RULE2]
              nxt_cyc = bcsd_pkg::CYC_TWO; // [RULE2]
            end
            bcsd_pkg::pointer_call_op:
            begin
              // low byte pushed now, high byte next cycle
              st_wr = 1'b1; // [RULE3]
              st_wdata = nxt_pc[7:0];
              nxt_ret_addr = nxt_pc;
              nxt_sp = sp_ff - bcsd_pkg::STEP_ONE;
              nxt_pc_pend = z_ptr_i; // [RULE3]
              nxt_cyc = bcsd_pkg::CYC_THREE; // [RULE3]
            end
            bcsd_pkg::subroutine_return_op:
            begin
              nxt_sp = sp_ff + bcsd_pkg::STEP_ONE; // [RULE13]
              nxt_cyc = bcsd_pkg::CYC_FOUR; // [RULE13]
            end
            bcsd_pkg::relative_jump_op:
            begin
              nxt_pc_pend = rel_target(pc_ff, offset_i); // [RULE12]
              nxt_cyc = bcsd_pkg::CYC_TWO; // [RULE12]
            end
            bcsd_pkg::compare_skip_equal_op,
            bcsd_pkg::skip_bit_clear_op,
            bcsd_pkg::skip_bit_set_op:
            begin
              if (op_i == bcsd_pkg::compare_skip_equal_op)
                cond = (rd_val_i == rr_val_i); // [RULE4]
              else if (op_i == bcsd_pkg::skip_bit_clear_op)
                cond = !rr_val_i[sel_i]; // [RULE6]
              else
                cond = rr_val_i[sel_i]; // [RULE7]
              nxt_pc_pend = pc_ff + skip_step(cond, next_long_i); // [RULE4] [RULE6] [RULE7]
              nxt_cyc = skip_cycles(cond, next_long_i); // [RULE4]
            end
            bcsd_pkg::branch_flag_set_op,
            bcsd_pkg::branch_flag_clear_op,
            bcsd_pkg::branch_equal_op,
            bcsd_pkg::branch_carry_clear_op:
            begin
              if (op_i == bcsd_pkg::branch_flag_set_op)
                cond = flags_ff[sel_i]; // [RULE8]
              else if (op_i == bcsd_pkg::branch_flag_clear_op)
                cond = !flags_ff[sel_i]; // [RULE9]
              else if (op_i == bcsd_pkg::branch_equal_op)
                cond = flags_ff[bcsd_pkg::FLAG_Z]; // [RULE10]
              else
                cond = !flags_ff[bcsd_pkg::FLAG_C]; // [RULE11]
              nxt_pc_pend = cond ? rel_target(pc_ff, offset_i) : nxt_pc; // [RULE8] [RULE9]
              nxt_cyc = cond ? bcsd_pkg::CYC_TWO : bcsd_pkg::CYC_ONE; // [RULE8]
            end
            default:
            begin
              nxt_done = 1'b1;
            end
          endcase
          // multi-cycle ops finish in WAIT so pc moves on the last cycle
          if (!nxt_done)
          begin
            if (nxt_cyc == bcsd_pkg::CYC_ONE)
            begin
              nxt_pc = nxt_pc_pend;
              nxt_done = 1'b1;
            end
            else if (op_i == bcsd_pkg::pointer_call_op)
              nxt_state = PUSH_HI;
            else if (op_i == bcsd_pkg::subroutine_return_op)
              nxt_state = POP_LO;
            else
            begin
              nxt_wait = nxt_cyc - bcsd_pkg::CYC_ONE;
              nxt_state = WAIT;
            end
          end
        end
      end
      PUSH_HI:
      begin
        st_wr = 1'b1;
        st_wdata = ret_addr_ff[15:8];
        nxt_sp = sp_ff - bcsd_pkg::STEP_ONE;
        nxt_wait = bcsd_pkg::CYC_ONE;
        nxt_state = WAIT;
      end
      POP_LO:
      begin
        // read data lands a cycle later, so pops are spaced out
        nxt_sp = sp_ff + bcsd_pkg::STEP_ONE;
        nxt_state = POP_HI;
      end
      POP_HI:
      begin
        // first byte back is the high byte, pushed last by the call
        nxt_pop_lo = st_rdata;
        nxt_state = WAIT;
        nxt_wait = bcsd_pkg::CYC_ONE;
      end
      WAIT:
      begin
        if (wait_ff == bcsd_pkg::CYC_ONE)
        begin
          nxt_pc = (cyc_ff == bcsd_pkg::CYC_FOUR) ? {pop_lo_ff, st_rdata} : pc_pend_ff; // [RULE13]
          nxt_done = 1'b1;
          nxt_state = IDLE;
        end
        else
          nxt_wait = wait_ff - bcsd_pkg::CYC_ONE;
      end
      default:
      begin
        nxt_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= IDLE;
      pc_ff <= bcsd_pkg::PC_RST;
      pc_pend_ff <= bcsd_pkg::PC_RST;
      flags_ff <= bcsd_pkg::FLAGS_RST;
      sp_ff <= bcsd_pkg::SP_RST;
      wait_ff <= 3'h0;
      cyc_ff <= 3'h0;
      done_ff <= 1'b0;
      pop_lo_ff <= 8'h00;
      ret_addr_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      pc_pend_ff <= nxt_pc_pend;
      flags_ff <= nxt_flags;
      sp_ff <= nxt_sp;
      wait_ff <= nxt_wait;
      cyc_ff <= nxt_cyc;
      done_ff <= nxt_done;
      pop_lo_ff <= nxt_pop_lo;
      ret_addr_ff <= nxt_ret_addr;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic busy_ff;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      busy_ff <= 1'b0;
    else
      busy_ff <= (nxt_state != IDLE);
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign pc_o = pc_ff;
  assign status_flags_o = flags_ff;
  assign sp_o = sp_ff;
  assign cycles_o = cyc_ff;

endmodule : bcsd_core
`default_nettype wire

//--- bcsd_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
module bcsd_core_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // instruction from fetch
  input wire logic issue_i,
  input wire logic [3:0] op_i,
  input wire logic [7:0] rd_val_i,
  input wire logic [7:0] rr_val_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] sel_i,
  input wire logic [11:0] offset_i,
  input wire logic next_long_i,
  input wire logic [15:0] z_ptr_i,
  // state outputs
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] status_flags_o,
  input wire logic [15:0] sp_o,
  input wire logic [2:0] cycles_o
);
  // ****************************************
  // helpers
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic take = issue_i && !busy_o;
  function automatic logic [15:0] tgt(logic [15:0] p, logic [11:0] k);
    return p + {{4{k[11]}}, k} + 16'h0001;
  endfunction : tgt
  sequence s_two;
    busy_o ##1 done_o;
  endsequence
  sequence s_three;
    busy_o [*2] ##1 done_o;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  chk_test_flags: assert property (take && op_i == bcsd_pkg::test_zero_minus_op |=>
    done_o && status_flags_o[1] == ($past(rd_val_i) == 8'h00)
    && status_flags_o[2] == $past(rd_val_i[7]) && !status_flags_o[3])
    else $error("test flags wrong");
  chk_jump_target: assert property (take && op_i == bcsd_pkg::pointer_jump_op |=>
    s_two ##0 pc_o == $past(z_ptr_i, 2) && $stable(status_flags_o))
    else $error("pointer jump wrong");
  chk_call_push: assert property (take && op_i == bcsd_pkg::pointer_call_op |=>
    s_three ##0 pc_o == $past(z_ptr_i, 3) && sp_o == $past(sp_o, 3) - 16'h0002)
    else $error("pointer call wrong");
  chk_compare_skip: assert property (take && op_i == bcsd_pkg::compare_skip_equal_op
    && rd_val_i == rr_val_i && next_long_i |=> s_three ##0 pc_o == $past(pc_o, 3) + 16'h0003)
    else $error("compare skip wrong");
  chk_imm_compare: assert property (take && op_i == bcsd_pkg::compare_immediate_op |=>
    status_flags_o[0] == ($past(rd_val_i) < $past(imm_i))
    && status_flags_o[1] == ($past(rd_val_i) == $past(imm_i)))
    else $error("compare immediate flags wrong");
  chk_bit_clear: assert property (take && op_i == bcsd_pkg::skip_bit_clear_op
    && !rr_val_i[sel_i] && !next_long_i |=> s_two ##0 pc_o == $past(pc_o, 2) + 16'h0002)
    else $error("skip on clear bit wrong");
  chk_bit_set: assert property (take && op_i == bcsd_pkg::skip_bit_set_op
    && !rr_val_i[sel_i] |=> done_o && pc_o == $past(pc_o) + 16'h0001)
    else $error("skip on set bit wrong");
  chk_equal_branch: assert property (take && op_i == bcsd_pkg::branch_equal_op
    && status_flags_o[1] |=> s_two ##0 pc_o == tgt($past(pc_o, 2), $past(offset_i, 2)))
    else $error("branch on equal wrong");
  chk_carry_branch: assert property (take && op_i == bcsd_pkg::branch_carry_clear_op
    && !status_flags_o[0] |=> s_two ##0 pc_o == tgt($past(pc_o, 2), $past(offset_i, 2)))
    else $error("branch on carry clear wrong");
  chk_rel_jump: assert property (take && op_i == bcsd_pkg::relative_jump_op |=>
    s_two ##0 pc_o == tgt($past(pc_o, 2), $past(offset_i, 2)))
    else $error("relative jump wrong");
  chk_return_pop: assert property (take && op_i == bcsd_pkg::subroutine_return_op |=>
    busy_o [*3] ##1 done_o && sp_o == $past(sp_o, 4) + 16'h0002)
    else $error("return wrong");
  chk_flag_set_branch: assert property (take && op_i == bcsd_pkg::branch_flag_set_op
    && status_flags_o[sel_i] |=> s_two ##0 pc_o == tgt($past(pc_o, 2), $past(offset_i, 2)))
    else $error("branch on flag set wrong");
  chk_flag_clear_fall: assert property (take && op_i == bcsd_pkg::branch_flag_clear_op
    && status_flags_o[sel_i] |=> done_o && pc_o == $past(pc_o) + 16'h0001
    && status_flags_o == $past(status_flags_o))
    else $error("branch on flag clear wrong");
endmodule : bcsd_core_properties
bind bcsd_core bcsd_core_properties i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .issue_i(issue_i), .op_i(op_i), .rd_val_i(rd_val_i), .rr_val_i(rr_val_i), .imm_i(imm_i),
  .sel_i(sel_i), .offset_i(offset_i), .next_long_i(next_long_i), .z_ptr_i(z_ptr_i),
  .busy_o(busy_o), .done_o(done_o), .pc_o(pc_o), .status_flags_o(status_flags_o),
  .sp_o(sp_o), .cycles_o(cycles_o));
`default_nettype wire

//--- bcsd_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bcsd_core_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic issue_i = 1'b0;
  logic [3:0] op_i = 4'h0;
  logic [7:0] rd_val_i = 8'h00;
  logic [7:0] rr_val_i = 8'h00;
  logic [7:0] imm_i = 8'h00;
  logic [2:0] sel_i = 3'h0;
  logic [11:0] offset_i = 12'h000;
  logic next_long_i = 1'b0;
  logic [15:0] z_ptr_i = 16'h0000;
  logic busy_o, done_o;
  logic [15:0] pc_o, sp_o;
  logic [7:0] status_flags_o;
  logic [2:0] cycles_o;
  int failures = 0;
  int cmp_count = 0;
  logic [15:0] pcm = 16'h0000;
  int ret;
  always #2 clock_i = ~clock_i;
  bcsd_core i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .op_i(op_i),
    .rd_val_i(rd_val_i), .rr_val_i(rr_val_i), .imm_i(imm_i), .sel_i(sel_i),
    .offset_i(offset_i), .next_long_i(next_long_i), .z_ptr_i(z_ptr_i), .busy_o(busy_o),
    .done_o(done_o), .pc_o(pc_o), .status_flags_o(status_flags_o), .sp_o(sp_o),
    .cycles_o(cycles_o));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // issue one op, wait for done under a bound, compare pc and cycle count
  task automatic go(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b,
    input logic [2:0] s, input logic [11:0] k, input logic l, input logic [15:0] z,
    input int ep, input logic [2:0] ec);
    int n;
    n = 0;
    @(posedge clock_i);
    issue_i <= 1'b1;
    op_i <= o;
    rd_val_i <= a;
    rr_val_i <= b;
    imm_i <= b;
    sel_i <= s;
    offset_i <= k;
    next_long_i <= l;
    z_ptr_i <= z;
    do
    begin
      @(posedge clock_i);
      issue_i <= 1'b0;
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 8);
    check(pc_o, ep[15:0]);
    check(n[15:0], {13'h0000, ec});
    check({13'h0000, cycles_o}, {13'h0000, ec});
    pcm = ep[15:0];
  endtask : go
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_alu;
    go(bcsd_pkg::test_zero_minus_op, 8'h80, 8'h00, 3'h0, 12'h000, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    check({8'h00, status_flags_o}, 16'h0014);
    go(bcsd_pkg::test_zero_minus_op, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    check({8'h00, status_flags_o}, 16'h0002);
    go(bcsd_pkg::compare_immediate_op, 8'h10, 8'h20, 3'h0, 12'h000, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    check({8'h00, status_flags_o}, 16'h0015);
    // signed overflow and a borrow out of the low nibble
    go(bcsd_pkg::compare_immediate_op, 8'h80, 8'h01, 3'h0, 12'h000, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    check({8'h00, status_flags_o}, 16'h0038);
    go(bcsd_pkg::compare_immediate_op, 8'h05, 8'h05, 3'h0, 12'h000, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    check({8'h00, status_flags_o}, 16'h0002);
    $display("alu test done");
  endtask : t_alu
  // flags now hold zero set and carry clear
  task automatic t_branch;
    go(bcsd_pkg::branch_equal_op, 8'h00, 8'h00, 3'h0, 12'hffe, 1'b0, 16'h0000,
      pcm - 1, 3'h2);
    go(bcsd_pkg::branch_carry_clear_op, 8'h00, 8'h00, 3'h0, 12'h005, 1'b0, 16'h0000,
      pcm + 6, 3'h2);
    check({8'h00, status_flags_o}, 16'h0002);
    go(bcsd_pkg::branch_flag_set_op, 8'h00, 8'h00, 3'h1, 12'h003, 1'b0, 16'h0000,
      pcm + 4, 3'h2);
    go(bcsd_pkg::branch_flag_set_op, 8'h00, 8'h00, 3'h0, 12'h003, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    go(bcsd_pkg::branch_flag_clear_op, 8'h00, 8'h00, 3'h1, 12'h003, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    go(bcsd_pkg::branch_flag_clear_op, 8'h00, 8'h00, 3'h0, 12'h002, 1'b0, 16'h0000,
      pcm + 3, 3'h2);
    check({8'h00, status_flags_o}, 16'h0002);
    $display("branch test done");
  endtask : t_branch
  task automatic t_skip;
    go(bcsd_pkg::compare_skip_equal_op, 8'h33, 8'h33, 3'h0, 12'h000, 1'b1, 16'h0000,
      pcm + 3, 3'h3);
    go(bcsd_pkg::compare_skip_equal_op, 8'h33, 8'h34, 3'h0, 12'h000, 1'b1, 16'h0000,
      pcm + 1, 3'h1);
    go(bcsd_pkg::skip_bit_clear_op, 8'h00, 8'hfe, 3'h0, 12'h000, 1'b0, 16'h0000,
      pcm + 2, 3'h2);
    go(bcsd_pkg::skip_bit_clear_op, 8'h00, 8'h01, 3'h0, 12'h000, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    go(bcsd_pkg::skip_bit_set_op, 8'h00, 8'h02, 3'h1, 12'h000, 1'b1, 16'h0000,
      pcm + 3, 3'h3);
    go(bcsd_pkg::skip_bit_set_op, 8'h00, 8'hfd, 3'h1, 12'h000, 1'b0, 16'h0000,
      pcm + 1, 3'h1);
    check({8'h00, status_flags_o}, 16'h0002);
    $display("skip test done");
  endtask : t_skip
  task automatic t_jump;
    go(bcsd_pkg::relative_jump_op, 8'h00, 8'h00, 3'h0, 12'h010, 1'b0, 16'h0000,
      pcm + 17, 3'h2);
    go(bcsd_pkg::pointer_jump_op, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0, 16'h1234,
      32'h00001234, 3'h2);
    ret = pcm + 1;
    go(bcsd_pkg::pointer_call_op, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0, 16'h0200,
      32'h00000200, 3'h3);
    check(sp_o, 16'h007d);
    go(bcsd_pkg::subroutine_return_op, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0, 16'h0000,
      ret, 3'h4);
    check(sp_o, 16'h007f);
    check({8'h00, status_flags_o}, 16'h0002);
    $display("jump test done");
  endtask : t_jump
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_alu();
    t_branch();
    t_skip();
    t_jump();
    wrap_up();
  end
  // the run needs well under a thousand cycles
  initial
  begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule : bcsd_core_tb
`default_nettype wire

//--- bcsd_pkg.sv
package bcsd_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PC_W = 16;
  localparam int DATA_W = 8;

  // ****************************************
  // status flag positions
  // ****************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h007f;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;

  // ****************************************
  // pc step sizes in words
  // ****************************************
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [15:0] STEP_THREE = 16'h0003;

  // ****************************************
  // operation codes presented by fetch
  // ****************************************
  typedef enum logic [3:0] {
    test_zero_minus_op = 4'h0,
    pointer_jump_op = 4'h1,
    pointer_call_op = 4'h2,
    compare_skip_equal_op = 4'h3,
    compare_immediate_op = 4'h4,
    skip_bit_clear_op = 4'h5,
    skip_bit_set_op = 4'h6,
    branch_flag_set_op = 4'h7,
    branch_flag_clear_op = 4'h8,
    branch_equal_op = 4'h9,
    branch_carry_clear_op = 4'ha,
    relative_jump_op = 4'hb,
    subroutine_return_op = 4'hc
  } bcsd_op_type;

endpackage : bcsd_pkg

//--- bcsd_stack.sv
`timescale 1ns/1ns
`default_nettype none
module bcsd_stack (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [6:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [6:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem [0:127];
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  always_comb
  begin
    nxt_rd_data = mem[rd_addr_i];
  end

  // memory array has no reset; contents are defined by pushes
  always_ff @(posedge clock_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_ff <= 8'h00;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_o = rd_data_ff;

endmodule : bcsd_stack
`default_nettype wire
